// [mgmt_defines.svh]
// Purpose: Shared constants for the management-mode controller and its system logic.
// Assumes: Byte addresses are 32 bits wide; the save area sits at a fixed offset from the base.
// Notes:   Offsets marked as chosen here have no fixed place in the save-area layout.
`ifndef MGMT_DEFINES_SVH
`define MGMT_DEFINES_SVH

// Base address after reset and entry-time offsets.
`define MM_BASE_RESET       32'h0003_0000
`define MM_SAVE_AREA_OFF    16'hFE00
`define MM_ENTRY_OFF        32'h0000_8000
`define MM_SAVE_AREA_BYTES  32'h0000_0200

// Save-area slots, as offsets from the base.
`define MM_OFF_CS_SEL       16'hFE10
`define MM_OFF_RESTART      16'hFEC8
`define MM_OFF_REVISION     16'hFEFC
`define MM_OFF_BASE_IMAGE   16'hFF00
`define MM_OFF_FLAGS        16'hFF70
`define MM_OFF_IP           16'hFF78
`define MM_SAVE_ITEMS       6

// Revision identifier: bit 17 flags base relocation; the low value is arbitrary.
`define MM_REV_RELOC_BIT    17
`define MM_REV_LOW_VALUE    32'h0000_0064

// Management RAM size limits and the fully backed top region.
`define MM_RAM_DEFAULT_BYTES 32'h0001_0000
`define MM_RAM_MIN_BYTES     32'h0000_8000
`define MM_TOP_BACKED_BYTES  32'h0000_8000

// Highest address reachable without a 32-bit address-size override.
`define MM_MAX_REAL_ADDR    32'h0010_FFEF

`endif

// [mgmt_if.sv]
// Purpose: Link between the processor's management-mode logic and the system logic.
// Assumes: One clock shared by both ends; the system answers every request one cycle later.
// Notes:   The device holds sys_mgmt_mode high for the whole stay in management mode.
`timescale 1ns/10ps
`default_nettype none

interface mgmt_if;
    logic        sys_mgmt_mode;
    logic        req;
    logic        we;
    logic [3:0]  be;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack;

    modport dev (output sys_mgmt_mode, output req, output we, output be, output addr, output wdata,
                 input rdata, input ack);
    modport sys (input sys_mgmt_mode, input req, input we, input be, input addr, input wdata,
                 output rdata, output ack);
endinterface : mgmt_if

`default_nettype wire

// [mgmt_mode_entry_exit_base_ctrl.sv]
// What this block does
// - Save processor state to management RAM first
// - Disable normal interrupts while in management mode
// - Resume instruction restores state, leaves mode
// - No translation; real-like addressing up to 4G
// - Restart flags are bits 0 and 1 of one 16-bit entry
// - Fault address register is never saved
// - No external writeback-and-invalidate input exists
// - Management RAM 64K default, 32K to 4G
// - System steers memory by mode entry/exit
// - Entry loads code selector, 3000h by default
// - System backs top 32K fully
// - Top 512 bytes form the save area
// - Base register resets to 30000h
// - Revision identifier bit 17 always set
// - Base changes only via saved image
// - Save at base+FE00h, fetch at base+8000h
// - Relocated base persists until changed or reset
// - 16-bit sizes, selector shifted four bits
// - Highest address without override is 10FFEFh
// - Software keeps relocated base below 4G
// - Software places handler at new base+8000h
//
// Purpose: Entry into and exit from system management mode, with the relocatable base register.
// Assumes: The system end acks each request exactly one cycle after it; handler holds h_req_in until h_ack_out.
// Notes:   A resume request waits until any handler access in flight has been answered.
//
// Implementation choices: the address-and-strobe port and the address map.
`include "mgmt_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module mgmt_mode_entry_exit_base_ctrl
    import mgmt_pkg::*;
#(
    parameter int unsigned SAVE_ITEMS = `MM_SAVE_ITEMS
) (
    // Clock and reset.
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    // Link to system logic.
    mgmt_if.dev              link,
    // Core events.
    input  wire logic        mgmt_interrupt_in,
    input  wire logic        mode_resume_instruction_in,
    // Core state to save.
    input  wire logic [15:0] core_cs_in,
    input  wire logic [31:0] core_ip_in,
    input  wire logic [31:0] core_flags_in,
    input  wire logic        auto_halt_in,
    input  wire logic        io_restart_in,
    // Handler memory access.
    input  wire logic        h_req_in,
    input  wire logic        h_we_in,
    input  wire logic [3:0]  h_be_in,
    input  wire logic [15:0] h_seg_in,
    input  wire logic [31:0] h_off_in,
    input  wire logic        h_addr32_in,
    input  wire logic [31:0] h_wdata_in,
    output logic             h_ack_out,
    output logic [31:0]      h_rdata_out,
    // Mode and control outputs.
    output logic             sys_mgmt_mode_out,
    output logic             int_enable_out,
    output logic             paging_enable_out,
    output logic             opsize16_out,
    output logic             fetch_start_out,
    output logic [31:0]      fetch_addr_out,
    output logic [15:0]      cs_sel_out,
    output logic [31:0]      mgmt_ram_base_out,
    output logic [31:0]      revision_id_out,
    // Restored state.
    output logic             restore_done_out,
    output logic [15:0]      restored_cs_out,
    output logic [31:0]      restored_ip_out,
    output logic [31:0]      restored_flags_out,
    output logic             restored_halt_out,
    output logic             restored_io_out
);

    localparam logic [2:0]  LAST_STEP = 3'(SAVE_ITEMS - 1);
    localparam logic [31:0] REV_ID    = `MM_REV_LOW_VALUE | (32'h0000_0001 << `MM_REV_RELOC_BIT);

    // Save-area slot for each step; save and restore walk the same list.
    function automatic logic [15:0] save_offset(input logic [2:0] idx);
        case (idx)
            3'd0:    save_offset = `MM_OFF_CS_SEL;
            3'd1:    save_offset = `MM_OFF_FLAGS;
            3'd2:    save_offset = `MM_OFF_IP;
            3'd3:    save_offset = `MM_OFF_RESTART;
            3'd4:    save_offset = `MM_OFF_REVISION;
            default: save_offset = `MM_OFF_BASE_IMAGE;
        endcase
    endfunction : save_offset

    // Real-mode-like address: selector shifted four bits plus a 16-bit offset, unless overridden.
    function automatic logic [31:0] real_addr(input logic [15:0] sel, input logic [31:0] off, input logic ovr);
        logic [31:0] seg_base;
        seg_base = {12'h000, sel, 4'h0};
        if (ovr) begin
            real_addr = seg_base + off;
        end else begin
            real_addr = seg_base + {16'h0000, off[15:0]};
        end
    endfunction : real_addr

    mode_state_t state_r;
    mode_state_t state_nxt;
    logic        irq_s1_r;
    logic        irq_s2_r;
    logic        irq_s3_r;
    logic        pend_r;
    logic        resume_r;
    logic        wait_r;
    logic [2:0]  step_r;
    logic [31:0] base_r;
    logic        req_r;
    logic        we_r;
    logic [3:0]  be_r;
    logic [31:0] addr_r;
    logic [31:0] wdata_r;

    // Decode of the current step and the handler path.
    wire         irq_edge   = irq_s2_r & ~irq_s3_r;
    wire         take       = (state_r == ST_NORMAL) & pend_r;
    wire         last_step  = (step_r == LAST_STEP);
    wire         seq_state  = (state_r == ST_SAVE) | (state_r == ST_RESTORE);
    wire         seq_issue  = seq_state & ~wait_r;
    wire         h_issue    = (state_r == ST_MGMT) & h_req_in & ~wait_r & ~h_ack_out & ~resume_r;
    wire         seq_ack    = seq_state & link.ack;
    wire [31:0]  area_addr  = base_r + {16'h0000, save_offset(step_r)};
    wire [31:0]  h_phys     = real_addr(h_seg_in, h_off_in, h_addr32_in);
    wire [3:0]   seq_be     = (step_r == 3'd3) ? 4'b0011 : 4'b1111;
    // The fault address register has no slot here, so the handler must keep it itself.
    wire [31:0]  save_word  = (step_r == 3'd0) ? {16'h0000, core_cs_in} :
                              (step_r == 3'd1) ? core_flags_in :
                              (step_r == 3'd2) ? core_ip_in :
                              (step_r == 3'd3) ? {24'h00_0000, 6'h00, auto_halt_in, io_restart_in} :
                              (step_r == 3'd4) ? REV_ID : base_r;

    // Next-state logic of the mode sequencer.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL: begin
                if (take) begin
                    state_nxt = ST_SAVE;
                end
            end
            ST_SAVE: begin
                if (seq_ack & last_step) begin
                    state_nxt = ST_MGMT;
                end
            end
            ST_MGMT: begin
                if (resume_r & ~wait_r & ~h_ack_out) begin
                    state_nxt = ST_RESTORE;
                end
            end
            ST_RESTORE: begin
                if (seq_ack & last_step) begin
                    state_nxt = ST_NORMAL;
                end
            end
            default: state_nxt = ST_NORMAL;
        endcase
    end

    // Interrupt pin synchroniser; the second and third stages feed the edge detector.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            irq_s1_r <= 1'b0;
            irq_s2_r <= 1'b0;
            irq_s3_r <= 1'b0;
        end else begin
            irq_s1_r <= mgmt_interrupt_in;
            irq_s2_r <= irq_s1_r;
            irq_s3_r <= irq_s2_r;
        end
    end

    // Pending interrupt and resume requests; a new event beats the clear in the same cycle.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pend_r   <= 1'b0;
            resume_r <= 1'b0;
        end else begin
            pend_r   <= irq_edge | (pend_r & ~take);
            resume_r <= ((state_r == ST_MGMT) & mode_resume_instruction_in) | (resume_r & (state_nxt == ST_MGMT));
        end
    end

    // State, step counter and the wait-for-ack flag.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_r <= ST_NORMAL;
            step_r  <= 3'd0;
            wait_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wait_r  <= (seq_issue | h_issue) | (wait_r & ~link.ack);
            step_r  <= (state_nxt != state_r) ? 3'd0 : (seq_ack ? step_r + 3'd1 : step_r);
        end
    end

    // Memory request registers toward the system logic.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            req_r   <= 1'b0;
            we_r    <= 1'b0;
            be_r    <= 4'b0000;
            addr_r  <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
        end else begin
            req_r <= seq_issue | h_issue;
            if (seq_issue) begin
                we_r    <= (state_r == ST_SAVE);
                be_r    <= seq_be;
                addr_r  <= area_addr;
                wdata_r <= save_word;
            end else if (h_issue) begin
                we_r    <= h_we_in;
                be_r    <= h_be_in;
                addr_r  <= h_phys;
                wdata_r <= h_wdata_in;
            end
        end
    end

    // Mode flags follow the next state so they change one cycle before the first save request.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sys_mgmt_mode_out <= 1'b0;
            int_enable_out    <= 1'b1;
            paging_enable_out <= 1'b1;
            opsize16_out      <= 1'b0;
            revision_id_out   <= REV_ID;
        end else begin
            sys_mgmt_mode_out <= (state_nxt != ST_NORMAL);
            int_enable_out    <= (state_nxt == ST_NORMAL);
            paging_enable_out <= (state_nxt == ST_NORMAL);
            opsize16_out      <= (state_nxt != ST_NORMAL);
            revision_id_out   <= REV_ID;
        end
    end

    // Base register: reset value, otherwise reloaded only from the saved image on exit.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            base_r <= `MM_BASE_RESET;
        end else if (seq_ack & (state_r == ST_RESTORE) & (step_r == 3'd5)) begin
            base_r <= link.rdata;
        end
    end

    // Entry outputs: handler fetch address and the code selector.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            fetch_start_out <= 1'b0;
            fetch_addr_out  <= 32'h0000_0000;
            cs_sel_out      <= 16'h0000;
        end else begin
            fetch_start_out <= seq_ack & last_step & (state_r == ST_SAVE);
            if (seq_ack & last_step & (state_r == ST_SAVE)) begin
                fetch_addr_out <= base_r + `MM_ENTRY_OFF;
                cs_sel_out     <= base_r[19:4];
            end
        end
    end

    // Handler answers and restored state.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            h_ack_out          <= 1'b0;
            h_rdata_out        <= 32'h0000_0000;
            restore_done_out   <= 1'b0;
            restored_cs_out    <= 16'h0000;
            restored_ip_out    <= 32'h0000_0000;
            restored_flags_out <= 32'h0000_0000;
            restored_halt_out  <= 1'b0;
            restored_io_out    <= 1'b0;
        end else begin
            h_ack_out        <= (state_r == ST_MGMT) & link.ack;
            restore_done_out <= seq_ack & last_step & (state_r == ST_RESTORE);
            if ((state_r == ST_MGMT) & link.ack) begin
                h_rdata_out <= link.rdata;
            end
            if (seq_ack & (state_r == ST_RESTORE)) begin
                case (step_r)
                    3'd0:    restored_cs_out    <= link.rdata[15:0];
                    3'd1:    restored_flags_out <= link.rdata;
                    3'd2:    restored_ip_out    <= link.rdata;
                    3'd3: begin
                        restored_io_out   <= link.rdata[0];
                        restored_halt_out <= link.rdata[1];
                    end
                    default: restored_cs_out <= restored_cs_out;
                endcase
            end
        end
    end

    // Link drive; there is deliberately no writeback-and-invalidate strobe on this port.
    assign link.req           = req_r;
    assign link.we            = we_r;
    assign link.be            = be_r;
    assign link.addr          = addr_r;
    assign link.wdata         = wdata_r;
    assign link.sys_mgmt_mode = sys_mgmt_mode_out;
    assign mgmt_ram_base_out  = base_r;

endmodule : mgmt_mode_entry_exit_base_ctrl

`default_nettype wire

// [mgmt_monitor.sv]
// Purpose: Protocol and sequence checks on the link between the controller and the system logic.
// Assumes: One clock; the system answers every request in the next cycle.
// Notes:   Save and restore order follows the six-slot layout of the save area.
`timescale 1ns/10ps
`default_nettype none

module mgmt_monitor (
    // Clock and reset.
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    // Link signals.
    input  wire logic        sys_mgmt_mode,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [3:0]  be,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        ack
);
    // Offsets are compared without the base, so relocation does not matter here.
    wire [15:0] addr_low;
    assign addr_low = addr[15:0];

    default clocking mon_cb @(posedge mclk_in);
    endclocking
    default disable iff (srst_in);

    ack_pair_a: assert property (req |=> ack) else $error("link ack missing");
    ack_cause_a: assert property (ack |-> $past(req)) else $error("link ack without request");
    req_gap_a: assert property (req |=> !req) else $error("link requests too close");
    req_mode_a: assert property (req |-> sys_mgmt_mode ##1 sys_mgmt_mode) else $error("request outside mode");
    mode_hold_a: assert property ($rose(sys_mgmt_mode) |-> sys_mgmt_mode [*8]) else $error("mode too short");
    save_order_a: assert property ($rose(sys_mgmt_mode) |-> ##[0:1] (req && we && addr_low == 16'hFE10)
        ##3 (req && we && addr_low == 16'hFF70) ##3 (req && we && addr_low == 16'hFF78)
        ##3 (req && we && addr_low == 16'hFEC8 && be == 4'b0011)
        ##3 (req && we && addr_low == 16'hFEFC && wdata[17]) ##3 (req && we && addr_low == 16'hFF00))
        else $error("save sequence wrong");
    restore_order_a: assert property (req && !we && addr_low == 16'hFE10 |->
        ##3 (req && !we && addr_low == 16'hFF70) ##3 (req && !we && addr_low == 16'hFF78)
        ##3 (req && !we && addr_low == 16'hFEC8) ##3 (req && !we && addr_low == 16'hFEFC)
        ##3 (req && !we && addr_low == 16'hFF00)) else $error("restore sequence wrong");
    exit_after_a: assert property ($fell(sys_mgmt_mode) |-> $past(ack) && !$past(we)
        && $past(addr_low) == 16'hFF00) else $error("mode left before base reload");
endmodule : mgmt_monitor

`default_nettype wire

// [mgmt_pkg.sv]
// Purpose: Types shared by the management-mode controller.
// Assumes: Constants live in mgmt_defines.svh.
// Notes:   One-hot state codes are written out.
package mgmt_pkg;

    typedef enum logic [3:0] {
        ST_NORMAL  = 4'b0001,
        ST_SAVE    = 4'b0010,
        ST_MGMT    = 4'b0100,
        ST_RESTORE = 4'b1000
    } mode_state_t;

endpackage : mgmt_pkg

// [mgmt_sys_logic.sv]
// Purpose: System logic that steers memory to management RAM while the processor is in management mode.
// Assumes: Management RAM aliases across its size; every request is answered in the next cycle.
// Notes:   A loader write in the same cycle as a link write to management RAM loses to the link.
`include "mgmt_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module mgmt_sys_logic #(
    parameter int unsigned MGMT_RAM_BYTES = `MM_RAM_DEFAULT_BYTES,
    parameter int unsigned MAIN_WORDS     = 1024
) (
    // Clock and reset.
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    // Link to the processor.
    mgmt_if.sys              link,
    // Loader into management RAM.
    input  wire logic        load_we_in,
    input  wire logic [31:0] load_addr_in,
    input  wire logic [31:0] load_data_in,
    // Status.
    output logic             mgmt_selected_out
);

    // Whole RAM is backed, which covers the top region that must always be present.
    localparam int unsigned MGMT_WORDS = MGMT_RAM_BYTES / 4;
    localparam int unsigned MGMT_AW    = $clog2(MGMT_WORDS);
    localparam int unsigned MAIN_AW    = $clog2(MAIN_WORDS);

    logic [31:0] mgmt_mem [MGMT_WORDS];
    logic [31:0] main_mem [MAIN_WORDS];
    logic [31:0] rdata_r;
    logic        ack_r;

    // Routing decode follows the mode line.
    wire               to_mgmt  = link.sys_mgmt_mode;
    wire [MGMT_AW-1:0] mgmt_idx = link.addr[MGMT_AW+1:2];
    wire [MAIN_AW-1:0] main_idx = link.addr[MAIN_AW+1:2];
    wire [MGMT_AW-1:0] load_idx = load_addr_in[MGMT_AW+1:2];

    // Memory arrays with byte-lane writes.
    always_ff @(posedge mclk_in) begin
        if (load_we_in & ~(link.req & link.we & to_mgmt)) begin
            mgmt_mem[load_idx] <= load_data_in;
        end
        if (link.req & link.we) begin
            for (int i = 0; i < 4; i++) begin
                if (link.be[i] & to_mgmt) begin
                    mgmt_mem[mgmt_idx][i*8 +: 8] <= link.wdata[i*8 +: 8];
                end
                if (link.be[i] & ~to_mgmt) begin
                    main_mem[main_idx][i*8 +: 8] <= link.wdata[i*8 +: 8];
                end
            end
        end
    end

    // One-cycle answer and routing status.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ack_r             <= 1'b0;
            rdata_r           <= 32'h0000_0000;
            mgmt_selected_out <= 1'b0;
        end else begin
            ack_r             <= link.req;
            mgmt_selected_out <= to_mgmt;
            if (link.req & ~link.we) begin
                rdata_r <= to_mgmt ? mgmt_mem[mgmt_idx] : main_mem[main_idx];
            end
        end
    end

    assign link.ack   = ack_r;
    assign link.rdata = rdata_r;

endmodule : mgmt_sys_logic

`default_nettype wire

// [test_mgmt_mode_entry_exit_base_ctrl.sv]
// Purpose: Self-checking bench joining the controller and the system logic.
// Assumes: Handler accesses are made while the controller is in management mode; refused() tries one before entry.
// Notes:   Core selector, IP and flags are held constant and the restart flags change only between entries, so restored values can be predicted.
`timescale 1ns/10ps
`default_nettype none

module test_mgmt_mode_entry_exit_base_ctrl;
    `define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
        $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
    int          err_count = 0;
    int          cmp_count = 0;
    logic        mclk_in = 0, srst_in = 1, irq = 0, mode_resume_instruction = 0, h_req = 0, h_we = 0, h_a32 = 0, load_we = 0;
    logic        a_halt = 1, io_rst = 0;
    logic [3:0]  h_be = 4'hF;
    logic [15:0] h_seg = '0;
    logic [31:0] h_off = '0, h_wd = '0, load_addr = '0, load_data = '0, rd, la;
    logic        h_ack, fstart, ie, pe, op16, rdone, rhalt, rio, msel, mode;
    logic [15:0] cs_sel, rcs;
    logic [31:0] h_rd, faddr, base, rev, rip, rflags;

    mgmt_if i_mgmt_if ();
    mgmt_mode_entry_exit_base_ctrl i_mgmt_mode_entry_exit_base_ctrl (.mclk_in(mclk_in), .srst_in(srst_in),
        .link(i_mgmt_if), .mgmt_interrupt_in(irq), .mode_resume_instruction_in(mode_resume_instruction),
        .core_cs_in(16'h1234), .core_ip_in(32'h0000_5678), .core_flags_in(32'h0000_0202),
        .auto_halt_in(a_halt), .io_restart_in(io_rst), .h_req_in(h_req), .h_we_in(h_we), .h_be_in(h_be),
        .h_seg_in(h_seg), .h_off_in(h_off), .h_addr32_in(h_a32), .h_wdata_in(h_wd), .h_ack_out(h_ack),
        .h_rdata_out(h_rd), .sys_mgmt_mode_out(mode), .int_enable_out(ie), .paging_enable_out(pe),
        .opsize16_out(op16), .fetch_start_out(fstart), .fetch_addr_out(faddr), .cs_sel_out(cs_sel),
        .mgmt_ram_base_out(base), .revision_id_out(rev), .restore_done_out(rdone), .restored_cs_out(rcs),
        .restored_ip_out(rip), .restored_flags_out(rflags), .restored_halt_out(rhalt), .restored_io_out(rio));
    mgmt_sys_logic #(.MGMT_RAM_BYTES(32'h0000_8000), .MAIN_WORDS(64)) i_mgmt_sys_logic (.mclk_in(mclk_in),
        .srst_in(srst_in), .link(i_mgmt_if), .load_we_in(load_we), .load_addr_in(load_addr),
        .load_data_in(load_data), .mgmt_selected_out(msel));
    mgmt_monitor i_mgmt_monitor (.mclk_in(mclk_in), .srst_in(srst_in), .sys_mgmt_mode(i_mgmt_if.sys_mgmt_mode),
        .req(i_mgmt_if.req), .we(i_mgmt_if.we), .be(i_mgmt_if.be), .addr(i_mgmt_if.addr),
        .wdata(i_mgmt_if.wdata), .ack(i_mgmt_if.ack));

    // Free-running 50 MHz clock.
    always #10 mclk_in = ~mclk_in;

    // Prints the verdict and ends the run.
    task automatic results();
        if (err_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results

    // Waits a bounded time for the fetch pulse (sel 0) or the restore pulse (sel 1).
    task automatic await_pulse(input int sel);
        int   i;
        logic hit;
        hit = 0;
        for (i = 0; i < 60 && !hit; i++) begin
            @(posedge mclk_in);
            hit = (sel == 0) ? (fstart === 1'b1) : (rdone === 1'b1);
        end
        `CHK("pulse", 1'b1, hit)
    endtask : await_pulse

    // One handler access, held until acknowledged; la is the link address seen.
    task automatic hacc(input logic w, input logic [15:0] seg, input logic [31:0] off, input logic a32,
                        input logic [31:0] wd);
        int   i;
        logic done;
        done = 0;
        @(posedge mclk_in);
        h_req <= 1;
        h_we  <= w;
        h_seg <= seg;
        h_off <= off;
        h_a32 <= a32;
        h_wd  <= wd;
        for (i = 0; i < 10 && !done; i++) begin
            @(posedge mclk_in);
            if (i_mgmt_if.req === 1'b1) la = i_mgmt_if.addr;
            if (h_ack === 1'b1) begin
                rd = h_rd;
                done = 1;
            end
        end
        h_req <= 0;
        `CHK("h_ack", 1'b1, done)
    endtask : hacc

    // Handler requests outside the mode must go unanswered.
    task automatic refused();
        int   i;
        logic seen;
        seen = 0;
        @(posedge mclk_in);
        h_req <= 1;
        for (i = 0; i < 6; i++) begin
            @(posedge mclk_in);
            if (h_ack !== 1'b0 || i_mgmt_if.req !== 1'b0) seen = 1;
        end
        h_req <= 0;
        `CHK("refused", 1'b0, seen)
    endtask : refused

    // Raises the interrupt and checks the state at handler start.
    task automatic enter(input logic [31:0] b);
        @(posedge mclk_in);
        irq <= 1;
        await_pulse(0);
        `CHK("fetch_addr", b + 32'h0000_8000, faddr)
        `CHK("cs_sel", b[19:4], cs_sel)
        `CHK("int_enable", 1'b0, ie)
        `CHK("paging", 1'b0, pe)
        `CHK("opsize16", 1'b1, op16)
        `CHK("mode", 1'b1, mode)
        `CHK("selected", 1'b1, msel)
        irq <= 0;
    endtask : enter

    // Resumes and checks the restored state and base.
    task automatic leave(input logic [31:0] b);
        @(posedge mclk_in);
        mode_resume_instruction <= 1;
        @(posedge mclk_in);
        mode_resume_instruction <= 0;
        await_pulse(1);
        @(posedge mclk_in);
        `CHK("rcs", 16'h1234, rcs)
        `CHK("rip", 32'h0000_5678, rip)
        `CHK("rflags", 32'h0000_0202, rflags)
        `CHK("rhalt", a_halt, rhalt)
        `CHK("rio", io_rst, rio)
        `CHK("paging", 1'b1, pe)
        `CHK("opsize16", 1'b0, op16)
        `CHK("base", b, base)
        `CHK("int_enable", 1'b1, ie)
        `CHK("mode", 1'b0, mode)
        `CHK("selected", 1'b0, msel)
    endtask : leave

    // Main sequence.
    initial begin
        repeat (2) @(posedge mclk_in);
        srst_in <= 0;
        @(posedge mclk_in);
        `CHK("base_rst", 32'h0003_0000, base)
        `CHK("rev_bit", 1'b1, rev[17])
        `CHK("ie_rst", 1'b1, ie)
        load_we   <= 1;
        load_addr <= 32'h0003_8000;
        load_data <= 32'hC0DE_0001;
        @(posedge mclk_in);
        load_we <= 0;
        refused();
        enter(32'h0003_0000);
        hacc(0, 16'h3000, 32'h0000_FF00, 0, '0);
        `CHK("base_image", 32'h0003_0000, rd)
        hacc(0, 16'h3000, 32'h0000_FEFC, 0, '0);
        `CHK("saved_rev", 1'b1, rd[17])
        hacc(0, 16'h3000, 32'h0000_FF78, 0, '0);
        `CHK("saved_ip", 32'h0000_5678, rd)
        hacc(0, 16'h3000, 32'h0000_8000, 0, '0);
        `CHK("entry_code", 32'hC0DE_0001, rd)
        hacc(0, 16'hFFFF, 32'h0001_FFFF, 0, '0);
        `CHK("max_real", 32'h0010_FFEF, la)
        hacc(0, 16'h0000, 32'h0012_3450, 1, '0);
        `CHK("addr32", 32'h0012_3450, la)
        hacc(1, 16'h3000, 32'h0000_FF00, 0, 32'h0004_0000);
        leave(32'h0004_0000);
        // Swap the restart flags and place the handler at the new entry before the next entry.
        a_halt    <= 0;
        io_rst    <= 1;
        load_we   <= 1;
        load_addr <= 32'h0004_8000;
        load_data <= 32'hC0DE_0002;
        @(posedge mclk_in);
        load_we <= 0;
        enter(32'h0004_0000);
        hacc(0, 16'h4000, 32'h0000_8000, 0, '0);
        `CHK("new_entry", 32'hC0DE_0002, rd)
        leave(32'h0004_0000);
        srst_in <= 1;
        repeat (2) @(posedge mclk_in);
        srst_in <= 0;
        @(posedge mclk_in);
        `CHK("base_rerst", 32'h0003_0000, base)
        results();
    end

    // Cuts a hang short; the tests need well under 1000 cycles.
    initial begin
        #100us;
        err_count++;
        results();
    end
endmodule : test_mgmt_mode_entry_exit_base_ctrl

`default_nettype wire
